// [hdl/osdc_pkg.sv]
// Shared constants, types and helpers of the on-die termination sequencer
package osdc_pkg;

	// ----------------------------------------------------------------
	// Widths and pipeline depths
	// ----------------------------------------------------------------
	localparam int LAT_W     = 6;
	localparam int LEN_W     = 4;
	localparam int DLY_DEPTH = 64;
	localparam logic [7:0] TAP_MAX  = 8'h3F;
	// Pin path: two sync flops plus the output flop
	localparam logic [7:0] PIN_PIPE = 8'h03;
	localparam logic [7:0] OUT_PIPE = 8'h01;

	// ----------------------------------------------------------------
	// Latency offsets in clock cycles
	// ----------------------------------------------------------------
	localparam logic [7:0] X_PRE1 = 8'h02;
	localparam logic [7:0] X_PRE2 = 8'h03;
	localparam logic [LEN_W-1:0] PRE2_EXTRA  = 4'h1;
	localparam logic [LEN_W-1:0] ONE_LEN     = 4'h1;
	localparam logic [LEN_W-1:0] LEN_MAX     = 4'hF;
	localparam logic [LEN_W-1:0] RD_LEN_BC4  = 4'h4;
	localparam logic [LEN_W-1:0] RD_LEN_BL8  = 4'h6;
	localparam logic [LEN_W-1:0] HOLD_BC4    = 4'h4;
	localparam logic [LEN_W-1:0] HOLD_BL8    = 4'h6;
	localparam logic [LEN_W-1:0] WR4_P1      = 4'h4;
	localparam logic [LEN_W-1:0] WR4_P1_CRC  = 4'h7;
	localparam logic [LEN_W-1:0] WR4_P2      = 4'h5;
	localparam logic [LEN_W-1:0] WR4_P2_CRC  = 4'h8;
	localparam logic [LEN_W-1:0] WR8_P1      = 4'h6;
	localparam logic [LEN_W-1:0] WR8_P1_CRC  = 4'h7;
	localparam logic [LEN_W-1:0] WR8_P2      = 4'h7;
	localparam logic [LEN_W-1:0] WR8_P2_CRC  = 4'h8;

	// ----------------------------------------------------------------
	// Mode field codes
	// ----------------------------------------------------------------
	localparam logic [2:0] WR_DYN_MASK = 3'h3;
	localparam logic [2:0] RTT_OFF     = 3'h0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		TERM_HIZ  = 2'h0,
		TERM_PARK = 2'h1,
		TERM_NOM  = 2'h2,
		TERM_WR   = 2'h3
	} osdc_term_t;

	typedef struct packed {
		logic [LAT_W-1:0] cwl;
		logic [LAT_W-1:0] cl;
		logic [LAT_W-1:0] al;
		logic [LAT_W-1:0] pl;
		logic             pre2;
		logic             crc;
	} osdc_mode_t;

	typedef struct packed {
		logic [LAT_W-1:0] pin_tap;
		logic [LAT_W-1:0] wr_tap;
		logic [LAT_W-1:0] rd_tap;
		logic [LEN_W-1:0] wr_len4;
		logic [LEN_W-1:0] wr_len8;
		logic [LEN_W-1:0] rd_len4;
		logic [LEN_W-1:0] rd_len8;
		logic [LEN_W-1:0] hold4;
		logic [LEN_W-1:0] hold8;
	} osdc_lat_t;

	// Latency minus fixed pipeline, clipped to the delay line range
	function automatic logic [LAT_W-1:0] tap_of(input logic [7:0] lat,
		input logic [7:0] pipe);
		logic [7:0] t;
		t = (lat > pipe) ? lat - pipe : 8'h00;
		return (t > TAP_MAX) ? TAP_MAX[LAT_W-1:0] : t[LAT_W-1:0];
	endfunction : tap_of

endpackage : osdc_pkg

// [hdl/osdc_shift.sv]
// Tapped delay line that carries command and pin events
`timescale 1ns/1ps
module osdc_shift #(
	parameter int W     = 2,
	parameter int DEPTH = 64,
	parameter int TAP_W = 6
) (
	input  wire logic             clk,
	input  wire logic             srst,
	input  wire logic [W-1:0]     d,
	input  wire logic [TAP_W-1:0] tap,
	output logic      [W-1:0]     q
);

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	logic [W-1:0] line_reg [DEPTH];

	always_ff @(posedge clk) begin
		if (srst) begin
			for (int i = 0; i < DEPTH; i++) begin
				line_reg[i] <= '0;
			end
		end else begin
			line_reg[0] <= d;
			for (int i = 1; i < DEPTH; i++) begin
				line_reg[i] <= line_reg[i-1];
			end
		end
	end

	// Read data come straight out of a stored stage
	assign q = line_reg[tap];

endmodule : osdc_shift

// [hdl/osdc_lat.sv]
// Latency and window length calculator for the termination sequencer
`timescale 1ns/1ps
module osdc_lat (
	input  wire logic                 clk,
	input  wire logic                 srst,
	input  osdc_pkg::osdc_mode_t      mode,
	output osdc_pkg::osdc_lat_t       lat
);

	// ----------------------------------------------------------------
	// Derivation
	// ----------------------------------------------------------------
	logic [7:0]          wl;
	logic [7:0]          rl;
	logic [7:0]          x;
	logic [7:0]          dodt;
	logic [7:0]          roff;
	logic [osdc_pkg::LEN_W-1:0] extra;
	osdc_pkg::osdc_lat_t lat_next;

	always_comb begin
		wl = {2'b00, mode.cwl} + {2'b00, mode.al} + {2'b00, mode.pl};
		rl = {2'b00, mode.cl} + {2'b00, mode.al} + {2'b00, mode.pl};
		x = mode.pre2 ? osdc_pkg::X_PRE2 : osdc_pkg::X_PRE1;
		extra = mode.pre2 ? osdc_pkg::PRE2_EXTRA : '0;
		dodt = wl - x;
		roff = rl - x;
		lat_next.pin_tap = osdc_pkg::tap_of(dodt, osdc_pkg::PIN_PIPE);
		lat_next.wr_tap = osdc_pkg::tap_of(dodt, osdc_pkg::OUT_PIPE);
		lat_next.rd_tap = osdc_pkg::tap_of(roff, osdc_pkg::OUT_PIPE);
		lat_next.rd_len4 = osdc_pkg::RD_LEN_BC4 + extra;
		lat_next.rd_len8 = osdc_pkg::RD_LEN_BL8 + extra;
		lat_next.hold4 = osdc_pkg::HOLD_BC4 + extra;
		lat_next.hold8 = osdc_pkg::HOLD_BL8 + extra;
		case ({mode.pre2, mode.crc})
			2'b00: begin
				lat_next.wr_len4 = osdc_pkg::WR4_P1;
				lat_next.wr_len8 = osdc_pkg::WR8_P1;
			end
			2'b01: begin
				lat_next.wr_len4 = osdc_pkg::WR4_P1_CRC;
				lat_next.wr_len8 = osdc_pkg::WR8_P1_CRC;
			end
			2'b10: begin
				lat_next.wr_len4 = osdc_pkg::WR4_P2;
				lat_next.wr_len8 = osdc_pkg::WR8_P2;
			end
			default: begin
				lat_next.wr_len4 = osdc_pkg::WR4_P2_CRC;
				lat_next.wr_len8 = osdc_pkg::WR8_P2_CRC;
			end
		endcase
	end

	// Mode bits are static in use, so one register stage costs nothing
	always_ff @(posedge clk) begin
		if (srst) begin
			lat <= '0;
		end else begin
			lat <= lat_next;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (srst);

	pin_wr_same_a: assert property (
		lat.pin_tap != '0 |-> lat.wr_tap == lat.pin_tap + 6'h02)
		else $error("pin and write switch delays differ");

	// Reset is sampled, not current: the edge that ends reset still loads zero
	rd_len_pre_a: assert property (
		!srst |=> lat.rd_len4 == ($past(mode.pre2) ? 4'h5 : 4'h4))
		else $error("read restore offset wrong for preamble");

	crc_len_a: assert property (
		!srst && mode.crc |=> lat.wr_len4 == lat.wr_len8)
		else $error("crc write release offsets differ");

endmodule : osdc_lat

// [hdl/osdc_term_ctrl.sv]
// Synchronous and dynamic on-die termination sequencer, DLL on
`timescale 1ns/1ps

module osdc_term_ctrl (
	input  wire logic                    CLK,
	input  wire logic                    SRST,
	input  wire logic                    ODT_PIN,
	input  wire logic                    DLL_EN,
	input  wire logic                    DLL_LOCK,
	input  wire logic                    WR_CMD,
	input  wire logic                    RD_CMD,
	input  wire logic                    CMD_BC4,
	input  wire logic                    MR_BC4,
	input  wire logic [5:0]              CWL,
	input  wire logic [5:0]              CL,
	input  wire logic [5:0]              AL,
	input  wire logic [5:0]              PL,
	input  wire logic                    PRE2,
	input  wire logic                    CRC_EN,
	input  wire logic [2:0]              RTT_NOM,
	input  wire logic [2:0]              RTT_WR,
	input  wire logic [2:0]              RTT_PARK,
	output osdc_pkg::osdc_term_t         TERM_SEL,
	output logic      [2:0]              TERM_CODE,
	output logic                         SYNC_MODE,
	output logic                         HOLD_VIOL
);

	localparam int LW = osdc_pkg::LEN_W;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic pin_meta_reg;
	logic pin_sync_reg;
	logic pin_prev_reg;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pin_meta_reg <= 1'b0;
			pin_sync_reg <= 1'b0;
		end else begin
			pin_meta_reg <= ODT_PIN;
			pin_sync_reg <= pin_meta_reg;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			pin_prev_reg <= 1'b0;
		end else begin
			pin_prev_reg <= pin_sync_reg;
		end
	end

	// ----------------------------------------------------------------
	// Mode and latencies
	// ----------------------------------------------------------------
	logic                 sync_mode;
	osdc_pkg::osdc_mode_t mode;
	osdc_pkg::osdc_lat_t  lat;

	// No CKE or power-down term: the same timing holds in every state
	assign sync_mode = DLL_EN & DLL_LOCK;

	always_comb begin
		mode.cwl = CWL;
		mode.cl = CL;
		mode.al = AL;
		mode.pl = PL;
		mode.pre2 = PRE2;
		mode.crc = CRC_EN;
	end

	osdc_lat u_lat (
		.clk  (CLK),
		.srst (SRST),
		.mode (mode),
		.lat  (lat)
	);

	// ----------------------------------------------------------------
	// Command gating
	// ----------------------------------------------------------------
	logic dyn_en;
	logic wr_push;
	logic rd_push;

	// A zero write field leaves write commands invisible here
	assign dyn_en = sync_mode & |(RTT_WR & osdc_pkg::WR_DYN_MASK);
	assign wr_push = WR_CMD & dyn_en;
	assign rd_push = RD_CMD & sync_mode;

	// ----------------------------------------------------------------
	// Delay lines
	// ----------------------------------------------------------------
	logic       nom_q;
	logic [1:0] wr_q;
	logic [1:0] rd_q;

	osdc_shift #(
		.W     (1),
		.DEPTH (osdc_pkg::DLY_DEPTH),
		.TAP_W (osdc_pkg::LAT_W)
	) u_pin_line (
		.clk  (CLK),
		.srst (SRST),
		.d    (pin_sync_reg),
		.tap  (lat.pin_tap),
		.q    (nom_q)
	);

	osdc_shift #(
		.W     (2),
		.DEPTH (osdc_pkg::DLY_DEPTH),
		.TAP_W (osdc_pkg::LAT_W)
	) u_wr_line (
		.clk  (CLK),
		.srst (SRST),
		.d    ({CMD_BC4, wr_push}),
		.tap  (lat.wr_tap),
		.q    (wr_q)
	);

	osdc_shift #(
		.W     (2),
		.DEPTH (osdc_pkg::DLY_DEPTH),
		.TAP_W (osdc_pkg::LAT_W)
	) u_rd_line (
		.clk  (CLK),
		.srst (SRST),
		.d    ({CMD_BC4, rd_push}),
		.tap  (lat.rd_tap),
		.q    (rd_q)
	);

	// ----------------------------------------------------------------
	// Write and read windows
	// ----------------------------------------------------------------
	logic          wr_hit;
	logic          rd_hit;
	logic [LW-1:0] wr_cnt_reg;
	logic [LW-1:0] wr_cnt_next;
	logic [LW-1:0] rd_cnt_reg;
	logic [LW-1:0] rd_cnt_next;

	assign wr_hit = wr_q[0];
	assign rd_hit = rd_q[0];

	// A later burst reloads the count, so back-to-back bursts merge
	always_comb begin
		wr_cnt_next = wr_cnt_reg;
		if (!sync_mode) begin
			wr_cnt_next = '0;
		end else if (wr_hit) begin
			wr_cnt_next = wr_q[1] ? lat.wr_len4 : lat.wr_len8;
		end else if (wr_cnt_reg != '0) begin
			wr_cnt_next = wr_cnt_reg - osdc_pkg::ONE_LEN;
		end
	end

	always_comb begin
		rd_cnt_next = rd_cnt_reg;
		if (!sync_mode) begin
			rd_cnt_next = '0;
		end else if (rd_hit) begin
			rd_cnt_next = rd_q[1] ? lat.rd_len4 : lat.rd_len8;
		end else if (rd_cnt_reg != '0) begin
			rd_cnt_next = rd_cnt_reg - osdc_pkg::ONE_LEN;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			wr_cnt_reg <= '0;
		end else begin
			wr_cnt_reg <= wr_cnt_next;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			rd_cnt_reg <= '0;
		end else begin
			rd_cnt_reg <= rd_cnt_next;
		end
	end

	// ----------------------------------------------------------------
	// Termination selection
	// ----------------------------------------------------------------
	logic                 nom_next;
	osdc_pkg::osdc_term_t term_next;
	logic [2:0]           code_next;

	// Disabled nominal field falls back to park, as with the pin low
	assign nom_next = nom_q & (RTT_NOM != osdc_pkg::RTT_OFF);

	always_comb begin
		term_next = osdc_pkg::TERM_PARK;
		code_next = RTT_PARK;
		if (sync_mode) begin
			if (rd_cnt_next != '0) begin
				term_next = osdc_pkg::TERM_HIZ;
				code_next = osdc_pkg::RTT_OFF;
			end else if (wr_cnt_next != '0) begin
				term_next = osdc_pkg::TERM_WR;
				code_next = RTT_WR;
			end else if (nom_next) begin
				term_next = osdc_pkg::TERM_NOM;
				code_next = RTT_NOM;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			TERM_SEL <= osdc_pkg::TERM_PARK;
			TERM_CODE <= osdc_pkg::RTT_OFF;
		end else begin
			TERM_SEL <= term_next;
			TERM_CODE <= code_next;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			SYNC_MODE <= 1'b0;
		end else begin
			SYNC_MODE <= sync_mode;
		end
	end

	// ----------------------------------------------------------------
	// Pin hold monitor
	// ----------------------------------------------------------------
	// Write commands are not delayed like the pin, so the restart on a
	// write is two cycles early; the check errs on the lenient side
	logic [LW-1:0] hold_cnt_reg;
	logic [LW-1:0] hold_min;

	assign hold_min = MR_BC4 ? lat.hold4 : lat.hold8;

	always_ff @(posedge CLK) begin
		if (SRST) begin
			hold_cnt_reg <= '0;
		end else if (pin_sync_reg & (~pin_prev_reg | WR_CMD)) begin
			hold_cnt_reg <= osdc_pkg::ONE_LEN;
		end else if (pin_sync_reg && hold_cnt_reg != osdc_pkg::LEN_MAX) begin
			hold_cnt_reg <= hold_cnt_reg + osdc_pkg::ONE_LEN;
		end
	end

	always_ff @(posedge CLK) begin
		if (SRST) begin
			HOLD_VIOL <= 1'b0;
		end else begin
			HOLD_VIOL <= ~pin_sync_reg & pin_prev_reg
				& (hold_cnt_reg < hold_min);
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence rd_hit_s;
		sync_mode && rd_hit;
	endsequence

	sequence rd_long_s;
		sync_mode && rd_hit && !rd_q[1];
	endsequence

	dll_off_park_a: assert property (
		!sync_mode |=> TERM_SEL == osdc_pkg::TERM_PARK)
		else $error("termination not parked with DLL off");

	rd_hiz_span_a: assert property (
		rd_hit_s |=> (TERM_SEL == osdc_pkg::TERM_HIZ
			&& TERM_CODE == osdc_pkg::RTT_OFF || !SYNC_MODE) [*4])
		else $error("read disable shorter than four cycles");

	rd_bl8_span_a: assert property (
		rd_long_s |=> (TERM_SEL == osdc_pkg::TERM_HIZ || !SYNC_MODE) [*6])
		else $error("burst read disable shorter than six cycles");

	wr_over_nom_a: assert property (
		sync_mode && wr_hit && rd_cnt_next == '0
		|=> TERM_SEL == osdc_pkg::TERM_WR && TERM_CODE == $past(RTT_WR))
		else $error("write termination not selected");

	nom_follow_a: assert property (
		sync_mode && nom_q && RTT_NOM != osdc_pkg::RTT_OFF
		&& rd_cnt_next == '0 && wr_cnt_next == '0
		|=> TERM_SEL == osdc_pkg::TERM_NOM)
		else $error("nominal termination missing with pin high");

	park_low_a: assert property (
		!SRST && sync_mode && !nom_q && rd_cnt_next == '0 && wr_cnt_next == '0
		|=> TERM_SEL == osdc_pkg::TERM_PARK && TERM_CODE == $past(RTT_PARK))
		else $error("park termination missing with pin low");

	dll_wr_block_a: assert property (
		!sync_mode |=> wr_cnt_reg == '0 && rd_cnt_reg == '0)
		else $error("termination window kept with DLL off");

	dyn_off_a: assert property (
		(RTT_WR & osdc_pkg::WR_DYN_MASK) == 3'h0 |-> !wr_push)
		else $error("write termination armed with zero field");

	hold_ok_a: assert property (
		!pin_sync_reg && pin_prev_reg && hold_cnt_reg >= hold_min
		|=> !HOLD_VIOL)
		else $error("hold flag raised on a long enough pulse");

endmodule : osdc_term_ctrl

// [tb/osdc_ctrl_model.sv]
// Controller model driving the termination pin and command strobes
`timescale 1ns/1ps
module osdc_ctrl_model (
	input  wire logic clk,
	input  wire logic pre2,
	input  wire logic mr_bc4,
	output logic      odt_pin,
	output logic      wr_cmd,
	output logic      rd_cmd,
	output logic      cmd_bc4
);
	int hold_left;

	initial begin
		odt_pin = 1'b0;
		wr_cmd = 1'b0;
		rd_cmd = 1'b0;
		cmd_bc4 = 1'b0;
		hold_left = 0;
	end

	// Minimum high time of the pin, one more with the long preamble
	function automatic int min_hold();
		return (mr_bc4 ? 4 : 6) + int'(pre2);
	endfunction : min_hold

	// Returns at the first edge that samples the pin high
	task automatic pin_pulse(input int h, input bit short_ok);
		@(posedge clk);
		odt_pin <= 1'b1;
		// Counted from the first registered high edge
		hold_left <= (short_ok || h >= min_hold()) ? h : min_hold();
		@(posedge clk);
	endtask : pin_pulse

	// Returns at the edge that registers the command
	task automatic send(input bit wr, input bit bc4);
		@(posedge clk);
		wr_cmd <= wr;
		rd_cmd <= !wr;
		cmd_bc4 <= bc4;
		@(posedge clk);
		wr_cmd <= 1'b0;
		rd_cmd <= 1'b0;
		// Qualifier means nothing outside a command; never leave it steady
		cmd_bc4 <= !bc4;
	endtask : send

	always @(posedge clk) begin
		if (hold_left > 0) begin
			hold_left <= hold_left - 1;
			if (hold_left == 1)
				odt_pin <= 1'b0;
		end
	end
endmodule : osdc_ctrl_model

// [tb/testbench.sv]
// Self-checking bench of the termination sequencer
`timescale 1ns/1ps
module testbench;
	localparam int CWL_V = 9;
	localparam int CL_V  = 11;
	localparam int AL_V  = 2;
	localparam int PL_V  = 1;
	localparam int WL    = CWL_V + AL_V + PL_V;
	localparam int RL    = CL_V + AL_V + PL_V;
	localparam logic [2:0] PARK = 3'h1;

	logic                 clk;
	logic                 srst;
	logic                 dll_en;
	logic                 dll_lock;
	logic                 mr_bc4;
	logic                 pre2;
	logic                 crc_en;
	logic [2:0]           rtt_nom;
	logic [2:0]           rtt_wr;
	logic                 odt_pin;
	logic                 wr_cmd;
	logic                 rd_cmd;
	logic                 cmd_bc4;
	osdc_pkg::osdc_term_t term_sel;
	logic [2:0]           term_code;
	logic                 sync_mode;
	logic                 hold_viol;
	int                   fails;
	int                   n_checks;

	osdc_term_ctrl i_osdc_term_ctrl (
		.CLK(clk), .SRST(srst), .ODT_PIN(odt_pin), .DLL_EN(dll_en),
		.DLL_LOCK(dll_lock), .WR_CMD(wr_cmd), .RD_CMD(rd_cmd),
		.CMD_BC4(cmd_bc4), .MR_BC4(mr_bc4), .CWL(6'h09), .CL(6'h0B),
		.AL(6'h02), .PL(6'h01), .PRE2(pre2), .CRC_EN(crc_en),
		.RTT_NOM(rtt_nom), .RTT_WR(rtt_wr), .RTT_PARK(PARK),
		.TERM_SEL(term_sel), .TERM_CODE(term_code),
		.SYNC_MODE(sync_mode), .HOLD_VIOL(hold_viol)
	);

	osdc_ctrl_model i_osdc_ctrl_model (
		.clk(clk), .pre2(pre2), .mr_bc4(mr_bc4), .odt_pin(odt_pin),
		.wr_cmd(wr_cmd), .rd_cmd(rd_cmd), .cmd_bc4(cmd_bc4)
	);

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : close_out

	task automatic chk_sel(input osdc_pkg::osdc_term_t e);
		n_checks++;
		if (term_sel !== e) begin
			fails++;
			$display("[ERR] term_sel exp %0d got %0d t=%0t", e, term_sel, $time);
		end
	endtask : chk_sel

	task automatic chk_val(input string nm, input logic [2:0] e,
		input logic [2:0] g);
		n_checks++;
		if (g !== e) begin
			fails++;
			$display("[ERR] %s exp %0d got %0d t=%0t", nm, e, g, $time);
		end
	endtask : chk_val

	// Reset with a fresh mode set; latencies settle before any command
	task automatic setup(input logic p2, input logic crc, input logic [2:0] w);
		@(posedge clk);
		srst <= 1'b1;
		pre2 <= p2;
		crc_en <= crc;
		rtt_wr <= w;
		dll_en <= 1'b1;
		dll_lock <= 1'b1;
		repeat (16) @(posedge clk);
		#1;
		chk_sel(osdc_pkg::TERM_PARK);
		chk_val("term_code", 3'h0, term_code);
		chk_val("sync_mode", 3'h0, {2'h0, sync_mode});
		chk_val("hold_viol", 3'h0, {2'h0, hold_viol});
		@(posedge clk);
		srst <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk_val("sync_mode", 3'h1, {2'h0, sync_mode});
	endtask : setup

	// Expects state si from edge n to n+len-1 after the start, sb elsewhere
	task automatic check_window(input int n, input int len,
		input osdc_pkg::osdc_term_t si, input logic [2:0] ci,
		input osdc_pkg::osdc_term_t sb, input logic [2:0] cb);
		for (int i = 1; i <= n + len + 1; i++) begin
			@(posedge clk);
			#1;
			chk_sel((i >= n && i < n + len) ? si : sb);
			chk_val("term_code", (i >= n && i < n + len) ? ci : cb, term_code);
		end
	endtask : check_window

	task automatic count_viol(input int e);
		int n;
		n = 0;
		repeat (12) begin
			@(posedge clk);
			#1;
			if (hold_viol === 1'b1)
				n++;
		end
		chk_val("hold_viol_count", e[2:0], n[2:0]);
	endtask : count_viol

	function automatic int wr_len(input bit p2, input bit crc, input bit b4);
		if (crc)
			return p2 ? 8 : 7;
		if (p2)
			return b4 ? 5 : 7;
		return b4 ? 4 : 6;
	endfunction : wr_len

	initial begin
		fails = 0;
		n_checks = 0;
		repeat (20000) @(posedge clk);
		fails++;
		close_out();
	end

	initial begin
		srst = 1'b1;
		dll_en = 1'b1;
		dll_lock = 1'b1;
		mr_bc4 = 1'b1;
		pre2 = 1'b0;
		crc_en = 1'b0;
		rtt_nom = 3'h4;
		rtt_wr = 3'h2;
		for (int c = 0; c < 8; c++) begin
			setup(c[2], c[1], 3'h2);
			i_osdc_ctrl_model.send(1'b1, c[0]);
			check_window(WL - 2 - c[2], wr_len(c[2], c[1], c[0]),
				osdc_pkg::TERM_WR, 3'h2, osdc_pkg::TERM_PARK, PARK);
		end
		$display("test write_windows done");
		for (int c = 0; c < 4; c++) begin
			setup(c[1], 1'b0, 3'h2);
			i_osdc_ctrl_model.send(1'b0, c[0]);
			check_window(RL - 2 - c[1], (c[0] ? 4 : 6) + c[1],
				osdc_pkg::TERM_HIZ, 3'h0, osdc_pkg::TERM_PARK, PARK);
		end
		$display("test read_windows done");
		for (int c = 0; c < 3; c++) begin
			@(posedge clk);
			rtt_nom <= (c == 2) ? 3'h0 : 3'h4 + c[2:0];
			setup(c[0], 1'b0, 3'h2);
			i_osdc_ctrl_model.pin_pulse(8, 1'b0);
			check_window(WL - 2 - c[0], 8,
				(c == 2) ? osdc_pkg::TERM_PARK : osdc_pkg::TERM_NOM,
				(c == 2) ? PARK : 3'h4 + c[2:0],
				osdc_pkg::TERM_PARK, PARK);
		end
		$display("test pin_direct done");
		@(posedge clk);
		rtt_nom <= 3'h4;
		setup(1'b0, 1'b0, 3'h2);
		i_osdc_ctrl_model.pin_pulse(80, 1'b0);
		repeat (WL) @(posedge clk);
		i_osdc_ctrl_model.send(1'b1, 1'b0);
		check_window(WL - 2, 6, osdc_pkg::TERM_WR, 3'h2,
			osdc_pkg::TERM_NOM, 3'h4);
		i_osdc_ctrl_model.send(1'b0, 1'b1);
		check_window(RL - 2, 4, osdc_pkg::TERM_HIZ, 3'h0,
			osdc_pkg::TERM_NOM, 3'h4);
		i_osdc_ctrl_model.send(1'b1, 1'b1);
		i_osdc_ctrl_model.send(1'b1, 1'b0);
		// BC4 window opens two edges early and runs into the reloaded BL8 one
		check_window(WL - 4, 8, osdc_pkg::TERM_WR, 3'h2,
			osdc_pkg::TERM_NOM, 3'h4);
		$display("test overlap done");
		for (int c = 0; c < 5; c++) begin
			setup(1'b0, 1'b0, c[2:0]);
			i_osdc_ctrl_model.send(1'b1, 1'b0);
			check_window(WL - 2, 6,
				(c[1:0] != 0) ? osdc_pkg::TERM_WR : osdc_pkg::TERM_PARK,
				(c[1:0] != 0) ? c[2:0] : PARK,
				osdc_pkg::TERM_PARK, PARK);
		end
		$display("test write_codes done");
		setup(1'b0, 1'b0, 3'h2);
		i_osdc_ctrl_model.pin_pulse(40, 1'b0);
		repeat (WL) @(posedge clk);
		dll_lock <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
		chk_sel(osdc_pkg::TERM_PARK);
		chk_val("sync_mode", 3'h0, {2'h0, sync_mode});
		i_osdc_ctrl_model.send(1'b1, 1'b0);
		check_window(WL - 2, 6, osdc_pkg::TERM_PARK, PARK,
			osdc_pkg::TERM_PARK, PARK);
		@(posedge clk);
		dll_lock <= 1'b1;
		dll_en <= 1'b0;
		i_osdc_ctrl_model.send(1'b0, 1'b0);
		check_window(RL - 2, 6, osdc_pkg::TERM_PARK, PARK,
			osdc_pkg::TERM_PARK, PARK);
		$display("test dll_off done");
		setup(1'b0, 1'b0, 3'h2);
		i_osdc_ctrl_model.pin_pulse(2, 1'b1);
		count_viol(1);
		i_osdc_ctrl_model.pin_pulse(4, 1'b0);
		count_viol(0);
		@(posedge clk);
		mr_bc4 <= 1'b0;
		i_osdc_ctrl_model.pin_pulse(5, 1'b1);
		count_viol(1);
		i_osdc_ctrl_model.pin_pulse(6, 1'b0);
		count_viol(0);
		$display("test hold_monitor done");
		close_out();
	end
endmodule : testbench
